// File: common/psm_pkg.sv
/*
  Shared constants and types for the processor status and mode pin block.
  Assumes one 10 MHz bus clock; pin inputs are synchronised inside the block.
*/
package psm_pkg;

  // Status codes driven on the four status pins
  localparam logic [3:0] CODE_USER_RUN   = 4'h0;
  localparam logic [3:0] CODE_USER_SRCH  = 4'h4;
  localparam logic [3:0] CODE_HALTED     = 4'h5;
  localparam logic [3:0] CODE_RESERVED   = 4'h7;
  localparam logic [3:0] CODE_SUPV_RUN   = 4'h8;
  localparam logic [3:0] CODE_SUPV_TAKEN = 4'hB;
  localparam logic [3:0] CODE_SUPV_SRCH  = 4'hC;
  localparam logic [3:0] CODE_STOPPED    = 4'hD;
  localparam logic [3:0] CODE_RET_EXC    = 4'hE;
  localparam logic [3:0] CODE_STACKING   = 4'hF;

  // Field positions inside a status code
  localparam int CODE_SUP_BIT = 3;
  localparam int CODE_GRP_BIT = 2;

  // Boundary kinds form the low two code bits
  typedef enum logic [1:0] {
    BND_NONE      = 2'h0,
    BND_END       = 2'h1,
    BND_NOT_TAKEN = 2'h2,
    BND_TAKEN     = 2'h3
  } psm_bnd_t;

  // Class of the instruction that completes
  typedef enum logic [2:0] {
    OP_OTHER,
    OP_INT_COND_BRANCH,
    OP_DECREMENT_BRANCH,
    OP_FP_COND_BRANCH,
    OP_FLOW_CHANGE
  } psm_op_t;

  localparam int          SYNC_DEPTH    = 2;
  localparam logic [1:0]  STRAP_WAIT    = 2'h2;
  localparam logic [7:0]  AUTOVEC_BASE  = 8'h18;
  localparam logic [31:0] DATA_RESET    = 32'h0000_0000;

endpackage

// File: common/psm_ev_if.sv
/*
  Event bundle from the status sequencer to the status code encoder.
  Assumes both ends run on clk_sys; all fields are same-cycle levels.
*/
`timescale 1ns/1ps
interface psm_ev_if;
  logic              supervisor;
  logic              tableSearch;
  logic              halted;
  logic              stopped;
  logic              stacking;
  logic              retExc;
  logic              bndValid;
  logic              bndSup;
  psm_pkg::psm_bnd_t bndKind;

  modport src (output supervisor, tableSearch, halted, stopped, stacking,
               output retExc, bndValid, bndSup, bndKind);
  modport snk (input supervisor, tableSearch, halted, stopped, stacking,
               input retExc, bndValid, bndSup, bndKind);
endinterface

// File: hdl/psm_code_encoder.sv
/*
  Status code encoder: turns the event bundle into the next status code.
  Assumes the caller registers the result before it reaches the pins.
*/
`timescale 1ns/1ps
module psm_code_encoder (
  psm_ev_if.snk       ev,
  output logic [3:0]  code
);

  function automatic logic [3:0] bndCode(input logic sup, input psm_pkg::psm_bnd_t k);
    logic [3:0] c;
    c = {2'b00, k};
    c[psm_pkg::CODE_SUP_BIT] = sup;
    return c;
  endfunction

  wire [3:0] runCode  = ev.supervisor ? psm_pkg::CODE_SUPV_RUN : psm_pkg::CODE_USER_RUN;
  wire [3:0] srchCode = ev.supervisor ? psm_pkg::CODE_SUPV_SRCH : psm_pkg::CODE_USER_SRCH;
  wire [3:0] edgeCode = bndCode(ev.bndSup, ev.bndKind);

  // Halt and stop outrank everything; a boundary code beats stacking so
  // the one-cycle code is never swallowed by a back-to-back exception.
  // state codes follow levels
  assign code = ev.halted      ? psm_pkg::CODE_HALTED   :
                ev.stopped     ? psm_pkg::CODE_STOPPED  :
                ev.bndValid    ? edgeCode               :
                ev.stacking    ? psm_pkg::CODE_STACKING :
                ev.retExc      ? psm_pkg::CODE_RET_EXC  :
                ev.tableSearch ? srchCode               :
                runCode;

endmodule

// File: hdl/psm_status_pins.sv
/*
  Processor status and mode pin block: status code output, interrupt
  pending, autovector request, translation disable and data strobe latch.
  Assumes core event inputs are on clk_sys; pins arrive asynchronously.
*/
// Summary of operation
// - Pending output rises when recognised request level exceeds the status mask.
// - Four-bit status code changes only on the bus clock.
// - Present-state codes hold for as long as the state lasts.
// - With nothing else active, show 0 in user, 8 in supervisor.
// - Boundary codes last exactly one clock per instruction, one at a time.
// - User codes 1,2,3,4; supervisor codes 9,A,B,C for same meanings.
// - Code 5 on double-fault halt, D when stopped; 7 never driven.
// - Code F while stacking, E during return; stacking ends with code B.
// - Branch-taken code marks pending flow change, also after stacking.
// - Only integer and decrement branches give not-taken; untaken fp branch gives end.
// - Back-to-back single-clock instructions give one end code per clock.
// - Aborted instruction gives no end code; stacking then B follows.
// - Two interrupts give end, stacking, B, stacking, B.
// - Return after instruction gives end, return code, then branch-taken.
// - Translation disable stops translation but keeps cached translations.
// - Disable level caught at reset: high normal, low strobe latch mode.
// - In strobe latch mode, read data is captured on the external strobe.
`timescale 1ns/1ps
module psm_status_pins (
  input  wire logic                clk_sys,
  input  wire logic                resetn,
  input  wire logic                coreInstrEnd,
  input  wire psm_pkg::psm_op_t    coreOpClass,
  input  wire logic                coreBranchTaken,
  input  wire logic                coreAbort,
  input  wire logic                coreSupervisor,
  input  wire logic                coreTableSearch,
  input  wire logic                coreHalted,
  input  wire logic                coreStopped,
  input  wire logic                coreStacking,
  input  wire logic                coreRetExc,
  input  wire logic [2:0]          statusWordMask,
  input  wire logic                coreIntAck,
  input  wire logic                coreReadCycle,
  input  wire logic [2:0]          irqLevelInN,
  input  wire logic                autoVectorReqN,
  input  wire logic                transferAckN,
  input  wire logic                xlateDisableN,
  input  wire logic                readDataStrobe,
  input  wire logic [31:0]         dataIn,
  output logic [3:0]               procStateCode,
  output logic                     irqPendingOut,
  output logic [2:0]               irqLevel,
  output logic                     autoVecTake,
  output logic [7:0]               autoVecNum,
  output logic                     xlateEnable,
  output logic                     strobeLatchMode,
  output logic [31:0]              readData,
  output logic                     readDataValid
);

  typedef enum logic [1:0] {SEQ_IDLE, SEQ_STACK, SEQ_RET} psm_seq_t;

  // Reset release through two flops
  logic       rstS1_q;
  logic       rstN;
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      rstS1_q <= 1'b0;
      rstN    <= 1'b0;
    end else begin
      rstS1_q <= 1'b1;
      rstN    <= rstS1_q;
    end
  end

  // Pin synchronisers; stage one feeds stage two only
  logic [2:0]  irqS1_q, irqS2_q;
  logic        avecS1_q, avecS2_q;
  logic        ackS1_q, ackS2_q;
  logic        xdisS1_q, xdisS2_q;
  logic        strbS1_q, strbS2_q, strbS3_q;
  logic [31:0] dataS1_q, dataS2_q;
  always_ff @(posedge clk_sys or negedge rstN) begin
    if (!rstN) begin
      irqS1_q  <= 3'h7;
      irqS2_q  <= 3'h7;
      avecS1_q <= 1'b1;
      avecS2_q <= 1'b1;
      ackS1_q  <= 1'b1;
      ackS2_q  <= 1'b1;
      xdisS1_q <= 1'b1;
      xdisS2_q <= 1'b1;
      strbS1_q <= 1'b0;
      strbS2_q <= 1'b0;
      strbS3_q <= 1'b0;
      dataS1_q <= psm_pkg::DATA_RESET;
      dataS2_q <= psm_pkg::DATA_RESET;
    end else begin
      irqS1_q  <= irqLevelInN;
      irqS2_q  <= irqS1_q;
      avecS1_q <= autoVectorReqN;
      avecS2_q <= avecS1_q;
      ackS1_q  <= transferAckN;
      ackS2_q  <= ackS1_q;
      xdisS1_q <= xlateDisableN;
      xdisS2_q <= xdisS1_q;
      strbS1_q <= readDataStrobe;
      strbS2_q <= strbS1_q;
      strbS3_q <= strbS2_q;
      dataS1_q <= dataIn;
      dataS2_q <= dataS1_q;
    end
  end

  wire [2:0] lvlNow   = ~irqS2_q;
  logic [2:0] lvlPrev_q;
  // A level is recognised only once two samples agree
  wire       lvlStable = (lvlNow == lvlPrev_q);
  wire       pendD     = lvlStable && (lvlNow > statusWordMask);

  wire ackOn  = ~ackS2_q;
  wire avecOn = ~avecS2_q;
  // autovector is only honoured with acknowledge in an ack cycle
  wire avecHit = coreIntAck && ackOn && avecOn;

  // Strap capture after the synchronisers have filled
  logic [1:0] strapCnt_q;
  logic       strapDone_q;
  wire        strapNow = !strapDone_q && (strapCnt_q == psm_pkg::STRAP_WAIT);

  wire strbRise   = strbS2_q && !strbS3_q;
  // strobe edge or clock-edge sample, chosen by the strap
  wire capStrobe  = strobeLatchMode && coreReadCycle && strbRise;
  wire capNormal  = !strobeLatchMode && coreReadCycle && ackOn;
  wire capture    = capStrobe || capNormal;

  // Sequencer for the virtual jump after stacking and return
  psm_seq_t seq_q, seq_d;
  wire stackExit = (seq_q == SEQ_STACK) && !coreStacking;
  wire retExit   = (seq_q == SEQ_RET) && !coreRetExc;
  wire seqExit   = stackExit || retExit;

  always_comb begin
    seq_d = seq_q;
    case (seq_q)
      SEQ_IDLE: begin
        if (coreStacking) begin
          seq_d = SEQ_STACK;
        end else if (coreRetExc) begin
          seq_d = SEQ_RET;
        end
      end
      SEQ_STACK: begin
        if (!coreStacking) begin
          seq_d = coreRetExc ? SEQ_RET : SEQ_IDLE;
        end
      end
      SEQ_RET: begin
        if (!coreRetExc) begin
          seq_d = coreStacking ? SEQ_STACK : SEQ_IDLE;
        end
      end
      default: seq_d = SEQ_IDLE;
    endcase
  end

  // only integer and decrement branches report not-taken
  function automatic psm_pkg::psm_bnd_t kindOf(input psm_pkg::psm_op_t op,
                                               input logic taken);
    psm_pkg::psm_bnd_t k;
    k = psm_pkg::BND_END;
    case (op)
      psm_pkg::OP_INT_COND_BRANCH,
      psm_pkg::OP_DECREMENT_BRANCH: begin
        k = taken ? psm_pkg::BND_TAKEN : psm_pkg::BND_NOT_TAKEN;
      end
      psm_pkg::OP_FP_COND_BRANCH: begin
        k = taken ? psm_pkg::BND_TAKEN : psm_pkg::BND_END;
      end
      psm_pkg::OP_FLOW_CHANGE: k = psm_pkg::BND_TAKEN;
      default: k = psm_pkg::BND_END;
    endcase
    return k;
  endfunction

  // an aborted instruction never reaches its end code
  wire instrDone = coreInstrEnd && !coreAbort;

  psm_ev_if ev ();
  assign ev.supervisor  = coreSupervisor;
  assign ev.tableSearch = coreTableSearch;
  assign ev.halted      = coreHalted;
  assign ev.stopped     = coreStopped;
  assign ev.stacking    = coreStacking;
  assign ev.retExc      = coreRetExc;
  // stacking and return both finish with supervisor branch-taken
  // the exit acts as a jump into the handler
  assign ev.bndValid    = seqExit || instrDone;
  assign ev.bndSup      = seqExit ? 1'b1 : coreSupervisor;
  assign ev.bndKind     = seqExit ? psm_pkg::BND_TAKEN : kindOf(coreOpClass, coreBranchTaken);

  wire [3:0] encCode;
  psm_code_encoder u_enc (
    .ev   (ev),
    .code (encCode)
  );

  always_ff @(posedge clk_sys or negedge rstN) begin
    if (!rstN) begin
      procStateCode <= psm_pkg::CODE_USER_RUN;
      seq_q         <= SEQ_IDLE;
    end else begin
      procStateCode <= encCode;
      seq_q         <= seq_d;
    end
  end

  always_ff @(posedge clk_sys or negedge rstN) begin
    if (!rstN) begin
      lvlPrev_q     <= 3'h0;
      irqPendingOut <= 1'b0;
      irqLevel      <= 3'h0;
      autoVecTake   <= 1'b0;
      autoVecNum    <= 8'h00;
    end else begin
      lvlPrev_q     <= lvlNow;
      irqPendingOut <= pendD;
      if (lvlStable) begin
        irqLevel <= lvlNow;
      end
      autoVecTake <= avecHit;
      if (avecHit) begin
        autoVecNum <= psm_pkg::AUTOVEC_BASE + {5'h00, irqLevel};
      end
    end
  end

  // strap latched once after reset, then frozen
  always_ff @(posedge clk_sys or negedge rstN) begin
    if (!rstN) begin
      strapCnt_q      <= 2'h0;
      strapDone_q     <= 1'b0;
      strobeLatchMode <= 1'b0;
    end else begin
      if (!strapDone_q) begin
        strapCnt_q <= strapCnt_q + 2'h1;
      end
      if (strapNow) begin
        strapDone_q     <= 1'b1;
        strobeLatchMode <= ~xdisS2_q;
      end
    end
  end

  // no flush is issued; cached entries just go unused while low
  always_ff @(posedge clk_sys or negedge rstN) begin
    if (!rstN) begin
      xlateEnable <= 1'b0;
    end else begin
      xlateEnable <= strapDone_q && xdisS2_q;
    end
  end

  always_ff @(posedge clk_sys or negedge rstN) begin
    if (!rstN) begin
      readData      <= psm_pkg::DATA_RESET;
      readDataValid <= 1'b0;
    end else begin
      readDataValid <= capture;
      if (capture) begin
        readData <= dataS2_q;
      end
    end
  end

  // Checks
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rstN);

  wire quiet = !coreHalted && !coreStopped;
  wire plainRun = quiet && !coreStacking && !coreRetExc && !coreTableSearch
                  && !seqExit && !instrDone;

  property p_irq_pend;
    (lvlNow > statusWordMask) && lvlStable |=> irqPendingOut;
  endproperty
  a_irq_pend: assert property (p_irq_pend) else $error("pending not raised");

  property p_halt_code;
    coreHalted |=> procStateCode == psm_pkg::CODE_HALTED;
  endproperty
  a_halt_code: assert property (p_halt_code) else $error("halt code wrong");

  property p_stop_code;
    !coreHalted && coreStopped |=> procStateCode == psm_pkg::CODE_STOPPED;
  endproperty
  a_stop_code: assert property (p_stop_code) else $error("stop code wrong");

  property p_no_reserved;
    procStateCode != psm_pkg::CODE_RESERVED;
  endproperty
  a_no_reserved: assert property (p_no_reserved) else $error("reserved code");

  sequence s_stack_end;
    quiet && coreStacking ##1 quiet && !coreStacking;
  endsequence
  property p_stack_b;
    s_stack_end |-> ##1 procStateCode == psm_pkg::CODE_SUPV_TAKEN;
  endproperty
  a_stack_b: assert property (p_stack_b) else $error("no B after stacking");

  property p_stack_show;
    quiet && coreStacking && !seqExit && !instrDone
      |=> procStateCode == psm_pkg::CODE_STACKING;
  endproperty
  a_stack_show: assert property (p_stack_show) else $error("stacking code wrong");

  property p_fp_end;
    quiet && instrDone && !seqExit && coreOpClass == psm_pkg::OP_FP_COND_BRANCH
      && !coreBranchTaken |=> procStateCode[1:0] == psm_pkg::BND_END;
  endproperty
  a_fp_end: assert property (p_fp_end) else $error("fp branch code wrong");

  property p_abort;
    quiet && coreInstrEnd && coreAbort && !seqExit && !coreStacking && !coreRetExc
      |=> procStateCode[1:0] == 2'b00;
  endproperty
  a_abort: assert property (p_abort) else $error("end code after abort");

  sequence s_two_ends;
    (quiet && instrDone && !seqExit && coreOpClass == psm_pkg::OP_OTHER) [*2];
  endsequence
  property p_b2b;
    s_two_ends |=> procStateCode[1:0] == psm_pkg::BND_END
      && $past(procStateCode[1:0]) == psm_pkg::BND_END;
  endproperty
  a_b2b: assert property (p_b2b) else $error("back to back end lost");

  property p_default;
    plainRun |=> procStateCode == ($past(coreSupervisor) ? psm_pkg::CODE_SUPV_RUN
                                                          : psm_pkg::CODE_USER_RUN);
  endproperty
  a_default: assert property (p_default) else $error("default code wrong");

  property p_strap_hold;
    strapDone_q |=> $stable(strobeLatchMode);
  endproperty
  a_strap_hold: assert property (p_strap_hold) else $error("strap changed");

  property p_xlate_off;
    !xlateDisableN [*3] |=> !xlateEnable;
  endproperty
  a_xlate_off: assert property (p_xlate_off) else $error("translation not off");

  property p_capture;
    capStrobe |=> readDataValid && readData == $past(dataS2_q);
  endproperty
  a_capture: assert property (p_capture) else $error("strobe data lost");

endmodule

// File: dv/psm_far_side.sv
/*
  Far side model: interrupt source, bus responder and strap driver.
  Assumes its tasks are called just after a clk_sys rising edge.
*/
`timescale 1ns/1ps
module psm_far_side (
  input  wire logic        clk_sys,
  output logic [2:0]       irqLevelInN,
  output logic             autoVectorReqN,
  output logic             transferAckN,
  output logic             xlateDisableN,
  output logic             readDataStrobe,
  output logic [31:0]      dataIn
);
  initial begin
    irqLevelInN    = 3'h7;
    autoVectorReqN = 1'h1;
    transferAckN   = 1'h1;
    xlateDisableN  = 1'h1;
    readDataStrobe = 1'h0;
    dataIn         = 32'hFFFF_FFFF;
  end

  task automatic setIrq(input logic [2:0] level);
    irqLevelInN <= ~level;
  endtask

  task automatic setDis(input logic v);
    xlateDisableN <= v;
  endtask

  // Released bus shows the inverse, so stale data never matches
  task automatic respond(input logic [31:0] value, input int waitCyc,
                         input logic strobed, input logic autoVec);
    // Keeps a fresh value off the edge that released the last one
    @(posedge clk_sys);
    repeat (waitCyc) @(posedge clk_sys);
    dataIn <= value;
    repeat (2) @(posedge clk_sys);
    if (strobed) begin
      readDataStrobe <= 1'b1;
    end else begin
      transferAckN   <= 1'b0;
      autoVectorReqN <= ~autoVec;
    end
    @(posedge clk_sys);
    readDataStrobe <= 1'b0;
    transferAckN   <= 1'b1;
    autoVectorReqN <= 1'b1;
    repeat (5) @(posedge clk_sys);
    dataIn <= ~value;
  endtask
endmodule

// File: dv/psm_status_pins_tb_top.sv
/*
  Self-checking bench for the status and mode pin block.
  Assumes the far side model drives every pin input.
*/
`timescale 1ns/1ps
module psm_status_pins_tb_top;
  logic             clk_sys        = 1'b0;
  logic             resetn         = 1'b0;
  logic             coreInstrEnd   = 1'b0;
  psm_pkg::psm_op_t coreOpClass    = psm_pkg::OP_OTHER;
  logic             coreBranchTaken = 1'b0;
  logic             coreAbort      = 1'b0;
  logic [5:0]       lv             = 6'h00;
  logic [2:0]       statusWordMask = 3'h0;
  logic             coreIntAck     = 1'b0;
  logic             coreReadCycle  = 1'b0;
  logic [2:0]       irqLevelInN;
  logic             autoVectorReqN;
  logic             transferAckN;
  logic             xlateDisableN;
  logic             readDataStrobe;
  logic [31:0]      dataIn;
  logic [3:0]       procStateCode;
  logic             irqPendingOut;
  logic [2:0]       irqLevel;
  logic             autoVecTake;
  logic [7:0]       autoVecNum;
  logic             xlateEnable;
  logic             strobeLatchMode;
  logic [31:0]      readData;
  logic             readDataValid;
  int               failures     = 0;
  int               total_checks = 0;
  logic [3:0]       codeQ[$];
  logic [31:0]      dataQ[$];
  logic [7:0]       vecQ[$];
  logic [3:0]       holdCode;
  logic             holdOk = 1'b0;
  logic             pS = 1'b0;
  logic             pR = 1'b0;
  logic [31:0]      r;

  psm_status_pins DUT (
    .clk_sys(clk_sys), .resetn(resetn), .coreInstrEnd(coreInstrEnd),
    .coreOpClass(coreOpClass), .coreBranchTaken(coreBranchTaken),
    .coreAbort(coreAbort), .coreSupervisor(lv[5]), .coreTableSearch(lv[4]),
    .coreHalted(lv[3]), .coreStopped(lv[2]), .coreStacking(lv[1]),
    .coreRetExc(lv[0]), .statusWordMask(statusWordMask),
    .coreIntAck(coreIntAck), .coreReadCycle(coreReadCycle),
    .irqLevelInN(irqLevelInN), .autoVectorReqN(autoVectorReqN),
    .transferAckN(transferAckN), .xlateDisableN(xlateDisableN),
    .readDataStrobe(readDataStrobe), .dataIn(dataIn),
    .procStateCode(procStateCode), .irqPendingOut(irqPendingOut),
    .irqLevel(irqLevel), .autoVecTake(autoVecTake), .autoVecNum(autoVecNum),
    .xlateEnable(xlateEnable), .strobeLatchMode(strobeLatchMode),
    .readData(readData), .readDataValid(readDataValid)
  );

  psm_far_side far (
    .clk_sys(clk_sys), .irqLevelInN(irqLevelInN),
    .autoVectorReqN(autoVectorReqN), .transferAckN(transferAckN),
    .xlateDisableN(xlateDisableN), .readDataStrobe(readDataStrobe),
    .dataIn(dataIn)
  );

  initial begin
    forever #50 clk_sys = ~clk_sys;
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp,
                       input string what);
    total_checks++;
    if (seen !== exp) begin
      failures++;
      $display("mismatch at %0t: %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask

  task automatic test_done();
    $display("checks %0d failures %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  // Priority: halt, stop, boundary, exit, stacking, return, search
  function automatic logic [3:0] expCode(input logic e, input psm_pkg::psm_op_t op,
                                         input logic tk, input logic ab,
                                         input logic [5:0] l);
    logic [1:0] bnd;
    bnd = 2'h1;
    if (op == psm_pkg::OP_INT_COND_BRANCH || op == psm_pkg::OP_DECREMENT_BRANCH) begin
      bnd = tk ? 2'h3 : 2'h2;
    end
    if ((op == psm_pkg::OP_FP_COND_BRANCH && tk) || op == psm_pkg::OP_FLOW_CHANGE) begin
      bnd = 2'h3;
    end
    if (l[3]) return 4'h5;
    if (l[2]) return 4'hD;
    if (e && !ab) return {l[5], 1'b0, bnd};
    if ((pS && !l[1]) || (pR && !l[0])) return 4'hB;
    if (l[1]) return 4'hF;
    if (l[0]) return 4'hE;
    return {l[5], l[4], 2'h0};
  endfunction

  task automatic step(input logic e, input psm_pkg::psm_op_t op, input logic tk,
                      input logic ab, input logic [5:0] l);
    @(posedge clk_sys);
    coreInstrEnd    <= e;
    coreOpClass     <= op;
    coreBranchTaken <= tk;
    coreAbort       <= ab;
    lv              <= l;
    codeQ.push_back(expCode(e, op, tk, ab, l));
    pS = l[1];
    pR = l[0];
  endtask

  task automatic idle(input logic [5:0] l, input int n);
    repeat (n) step(1'b0, psm_pkg::OP_OTHER, 1'b0, 1'b0, l);
  endtask

  task automatic settle(input int n);
    repeat (n) @(posedge clk_sys);
    @(negedge clk_sys);
  endtask

  task automatic doReset();
    @(posedge clk_sys);
    resetn <= 1'b0;
    settle(16);
    check(procStateCode, 4'h0, "code in reset");
    @(posedge clk_sys);
    resetn <= 1'b1;
    settle(8);
  endtask

  // Results checked one cycle after their cause was driven
  always @(negedge clk_sys) begin
    if (holdOk) check(procStateCode, holdCode, "status code");
    holdOk = codeQ.size() > 0;
    if (holdOk) holdCode = codeQ.pop_front();
    if (readDataValid !== 1'b0) begin
      if (dataQ.size() == 0) check(readDataValid, 1'b0, "stray data");
      else check(readData, dataQ.pop_front(), "read data");
    end
    if (autoVecTake !== 1'b0) begin
      if (vecQ.size() == 0) check(autoVecTake, 1'b0, "stray vector");
      else check(autoVecNum, vecQ.pop_front(), "vector");
    end
  end

  initial begin
    #2000000;
    failures++;
    test_done();
  end

  initial begin
    r = $urandom(32'h5BFBC00F);
    doReset();
    check(strobeLatchMode, 1'b0, "latch mode");
    check(xlateEnable, 1'b1, "xlate");
    idle(6'h00, 2);
    idle(6'h20, 2);
    for (int s = 0; s < 2; s++)
      for (int o = 0; o < 5; o++)
        for (int t = 0; t < 2; t++)
          step(1'b1, psm_pkg::psm_op_t'(o), t[0], 1'b0, {s[0], 5'h00});
    idle(6'h10, 3);
    idle(6'h30, 3);
    step(1'b1, psm_pkg::OP_OTHER, 1'b0, 1'b0, 6'h08);
    idle(6'h08, 2);
    step(1'b1, psm_pkg::OP_FLOW_CHANGE, 1'b0, 1'b0, 6'h24);
    idle(6'h24, 2);
    step(1'b1, psm_pkg::OP_OTHER, 1'b0, 1'b1, 6'h00);
    idle(6'h22, 3);
    idle(6'h20, 1);
    step(1'b1, psm_pkg::OP_OTHER, 1'b0, 1'b0, 6'h00);
    idle(6'h22, 2);
    idle(6'h20, 1);
    idle(6'h22, 2);
    idle(6'h20, 2);
    step(1'b1, psm_pkg::OP_OTHER, 1'b0, 1'b0, 6'h00);
    idle(6'h21, 2);
    idle(6'h20, 2);
    repeat (40) begin
      r = $urandom;
      step(r[0], psm_pkg::psm_op_t'(r[3:1] % 3'h5), r[4], 1'b0, {r[5], r[6], 4'h0});
    end
    idle(6'h00, 2);
    for (int l = 0; l < 8; l++) begin
      for (int m = 0; m < 8; m++) begin
        @(posedge clk_sys);
        statusWordMask <= m[2:0];
        far.setIrq(l[2:0]);
        settle(6);
        check(irqPendingOut, l > m, "pending");
      end
      check(irqLevel, l, "level");
    end
    @(posedge clk_sys);
    far.setIrq(3'h5);
    settle(6);
    @(posedge clk_sys);
    coreIntAck <= 1'b1;
    vecQ.push_back(psm_pkg::AUTOVEC_BASE + 8'h05);
    far.respond(32'h0, 1, 1'b0, 1'b1);
    coreIntAck <= 1'b0;
    coreReadCycle <= 1'b1;
    for (int w = 0; w < 3; w++) begin
      r = $urandom;
      if (w < 2) dataQ.push_back(r);
      far.respond(r, w * 5, w == 2, 1'b0);
    end
    coreReadCycle <= 1'b0;
    far.setDis(1'b0);
    settle(6);
    check(xlateEnable, 1'b0, "xlate off");
    doReset();
    check(strobeLatchMode, 1'b1, "strobe mode");
    @(posedge clk_sys);
    far.setDis(1'b1);
    coreReadCycle <= 1'b1;
    for (int w = 0; w < 2; w++) begin
      r = $urandom;
      if (w == 0) dataQ.push_back(r);
      far.respond(r, 2, w == 0, 1'b0);
    end
    coreReadCycle <= 1'b0;
    settle(4);
    check(xlateEnable, 1'b1, "xlate on");
    test_done();
  end
endmodule
